// ===== rfwd_periph_model.sv
// Peripheral register model behind the window decoder.
// Assumes read data is sampled while the request strobe is high.
`timescale 1ns/100ps
`default_nettype none
module rfwd_periph_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] regs_q [0:255];
    logic [7:0] last_q = 8'h5A;
    // Byte store; reserved places keep data too, unlike real silicon
    always_ff @(posedge i_clk) begin
        if (i_req && i_we) begin
            regs_q[i_addr[7:0]] <= i_wdata;
        end
        last_q <= o_rdata;
    end
    // Idle bus flips each cycle so stale data never looks valid
    assign o_rdata = i_req ? regs_q[i_addr[7:0]] : ~last_q;
endmodule
`default_nettype wire

// ===== rfwd_pkg.sv
// Register file window decode package: address map, field positions,
// reset values and encodings shared by the decoder, its checker and the bench.
// Assumes a 16-bit page-relative address with a separate page byte.
package rfwd_pkg;
    // ==========================================================
    // Address map
    localparam logic [15:0] RFWD_SFR_LO = 16'h0000;
    localparam logic [15:0] RFWD_SFR_HI = 16'h0017;
    localparam logic [15:0] RFWD_WSEL_ADDR = 16'h0014;
    localparam logic [15:0] RFWD_SP_LO = 16'h0018;
    localparam logic [15:0] RFWD_SP_HI = 16'h0019;
    localparam logic [15:0] RFWD_LGEN_LO = 16'h001A;
    localparam logic [15:0] RFWD_LGEN_HI = 16'h00FF;
    localparam logic [15:0] RFWD_UGEN_LO = 16'h0100;
    localparam logic [15:0] RFWD_UGEN_HI = 16'h03FF;
    localparam logic [15:0] RFWD_CRAM_LO = 16'h0400;
    localparam logic [15:0] RFWD_CRAM_HI = 16'h05FF;
    localparam logic [15:0] RFWD_PSFR_LO = 16'h1F00;
    localparam logic [15:0] RFWD_PSFR_HI = 16'h1FDF;
    localparam logic [15:0] RFWD_MSFR_LO = 16'h1FE0;
    localparam logic [15:0] RFWD_MSFR_HI = 16'h1FFF;
    localparam logic [15:0] RFWD_IRC_ADDR = 16'h1FE0;
    localparam logic [7:0] RFWD_PAGE_LO = 8'h00;
    localparam logic [7:0] RFWD_PAGE_HI = 8'hFF;
    // ==========================================================
    // Window bases in the lower register file
    localparam logic [15:0] RFWD_WBASE_32 = 16'h00E0;
    localparam logic [15:0] RFWD_WBASE_64 = 16'h00C0;
    localparam logic [15:0] RFWD_WBASE_128 = 16'h0080;
    // ==========================================================
    // Field positions and reset values
    localparam int RFWD_WSEL_HOLD_BIT = 7;
    localparam int RFWD_IRC_EXT_BIT = 6;
    localparam int RFWD_IRC_PIN_BIT = 7;
    localparam logic [7:0] RFWD_IRC_RESET = 8'h00;
    localparam logic [6:0] RFWD_WSEL_RESET = 7'h00;
    localparam logic [15:0] RFWD_SP_RESET = 16'h0000;
    localparam logic [7:0] RFWD_ALL_ONES = 8'hFF;
    localparam logic [2:0] RFWD_SP_STEP_64K = 3'h2;
    localparam logic [2:0] RFWD_SP_STEP_1M = 3'h4;
    // Code RAM size in bytes
    localparam int RFWD_CRAM_BYTES = 512;
    // Register RAM size (0000h..03FFh)
    localparam int RFWD_REG_BYTES = 1024;
    // ==========================================================
    // Access kinds and targets
    typedef enum logic [1:0] {
        RFWD_AM_DIRECT,
        RFWD_AM_INDIRECT,
        RFWD_AM_INDEXED
    } rfwd_mode_t;
    typedef enum logic [1:0] {
        RFWD_STK_NONE,
        RFWD_STK_PUSH,
        RFWD_STK_POP
    } rfwd_stk_t;
    typedef enum logic [2:0] {
        RFWD_TGT_REG,
        RFWD_TGT_CRAM,
        RFWD_TGT_PERIPH,
        RFWD_TGT_EXT,
        RFWD_TGT_ONES,
        RFWD_TGT_IRC
    } rfwd_tgt_t;
endpackage

// ===== rfwd_ram.sv
// Single-port byte memory with registered read data.
// Assumes one access per cycle from the decoder on the same clock.
`timescale 1ns/100ps
`default_nettype none
module rfwd_ram #(
    parameter int DEPTH = 512,
    parameter int AW = 9
) (
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_q [DEPTH];

    // ==========================================================
    // Storage; read data always registered
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem_q[i_addr] <= i_wdata;
            end
            o_rdata <= mem_q[i_addr];
        end
    end
endmodule
`default_nettype wire

// ===== rfwd_top.sv
// Register file, code RAM, stack pointer and window decode.
// Assumes the arithmetic unit issues at most one byte access per cycle;
// answers come one cycle after the request; the peripheral side answers
// on i_periph_rdata in the same cycle that o_periph_req is seen.
//
// Behaviour
// [RQ1] 512-byte code RAM at 0400h-05FFh, both pages
// [RQ2] Code RAM data only indirect/indexed, fetches zero-wait
// [RQ3] Code RAM never reachable through a window
// [RQ4] Control bit 6 sends code RAM range external
// [RQ5] Control bit 7 reads inverse of access pin
// [RQ6] Decode upper, lower, stack pointer, special ranges
// [RQ7] Lower and windowed locations reached directly
// [RQ8] Fetches from register file go external
// [RQ9] Stack pointer word at 0018h, otherwise plain RAM
// [RQ10] Call: decrement two or four, then push
// [RQ11] Return: pop, then increment same amount
// [RQ12] Software keeps stack pointer even, page 00h
// [RQ13] 0000h-0017h special registers, selector at 0014h
// [RQ14] Windowed memory-mapped registers read FFh, ignore writes
// [RQ15] Selector maps 32/64/128-byte segment onto top
// [RQ16] Selector bit 7 is bus-hold enable only
// [RQ17] Upper RAM direct only while windowed
// [RQ18] Window bases 00E0h, 00C0h, 0080h up to 00FFh
// [RQ19] Target offset equals direct minus window base
// [RQ20] Windowable peripheral space 1F00h-1FDFh
// [RQ21] Selection zero means no window
`timescale 1ns/100ps
`default_nettype none
module rfwd_top
    import rfwd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_external_access_pin_b,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic i_fetch,
    input wire rfwd_mode_t i_mode,
    input wire logic [7:0] i_page,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire rfwd_stk_t i_stk,
    input wire logic i_mode_1m,
    input wire logic [7:0] i_periph_rdata,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic o_ext_req,
    output logic [23:0] o_ext_addr,
    output logic o_periph_req,
    output logic o_periph_we,
    output logic [15:0] o_periph_addr,
    output logic [7:0] o_periph_wdata,
    output logic [15:0] o_stack_pointer,
    output logic o_bus_hold_enable
);
    // ==========================================================
    // Helpers
    function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // ==========================================================
    // State
    logic pin_meta_q, pin_sync_q;
    logic [6:0] wsel_q;
    logic hold_en_q;
    logic ext_sel_q;
    logic [15:0] sp_q;
    logic rvalid_q;
    rfwd_tgt_t tgt_q;
    logic [7:0] direct_q;
    logic ext_req_q;
    logic [23:0] ext_addr_q;
    logic preq_q, pwe_q;
    logic [15:0] paddr_q;
    logic [7:0] pwdata_q;

    // ==========================================================
    // Window decode: size from the leading one of the selection field
    logic w32, w64, w128, win_on;
    logic [15:0] wbase, wseg, woff;
    logic [15:0] seg32, seg64, seg128;
    assign w32 = wsel_q[6];
    assign w64 = !wsel_q[6] && wsel_q[5];
    assign w128 = !wsel_q[6] && !wsel_q[5] && wsel_q[4];
    assign win_on = (wsel_q != RFWD_WSEL_RESET) && (w32 || w64 || w128); // RQ21
    // Selector n, leading one kept, covers n*size; e.g. 4Ah*32 = 0940h
    assign seg32 = {4'h0, wsel_q[6:0], 5'h00};
    assign seg64 = {4'h0, wsel_q[5:0], 6'h00};
    assign seg128 = {4'h0, wsel_q[4:0], 7'h00};
    assign wbase = w32 ? RFWD_WBASE_32 : (w64 ? RFWD_WBASE_64 : RFWD_WBASE_128); // RQ18
    assign wseg = w32 ? seg32 : (w64 ? seg64 : seg128); // RQ15
    assign woff = i_addr - wbase; // RQ19

    // Products 0900h..0BFFh rebase down 0800h onto the upper file; all else
    // lands in 1xxxh, so only 0F00h..0FFFh can reach peripheral space.
    logic [15:0] seg_raw, win_tgt;
    logic seg_in_reg;
    assign seg_raw = wseg + woff;
    assign seg_in_reg = (seg_raw >= 16'h0900) && (seg_raw <= 16'h0BFF);
    assign win_tgt = seg_in_reg ? (seg_raw - 16'h0800) : (seg_raw | 16'h1000);

    // ==========================================================
    // Address classification
    logic page_ok, is_direct, hit_win, win_ureg, win_psfr, win_msfr;
    logic a_sfr, a_sp, a_lgen, a_ugen, a_cram, a_irc, a_psfr;
    assign page_ok = (i_page == RFWD_PAGE_LO) || (i_page == RFWD_PAGE_HI); // RQ1
    assign is_direct = (i_mode == RFWD_AM_DIRECT);
    assign hit_win = is_direct && win_on && (i_addr[15:8] == 8'h00)
                     && (i_addr >= wbase); // RQ7
    assign win_ureg = hit_win && in_rng(win_tgt, RFWD_UGEN_LO, RFWD_UGEN_HI); // RQ17 RQ3
    assign win_psfr = hit_win && in_rng(win_tgt, RFWD_PSFR_LO, RFWD_PSFR_HI); // RQ20
    assign win_msfr = hit_win && in_rng(win_tgt, RFWD_MSFR_LO, RFWD_MSFR_HI); // RQ14
    assign a_sfr = in_rng(i_addr, RFWD_SFR_LO, RFWD_SFR_HI); // RQ6 RQ13
    assign a_sp = in_rng(i_addr, RFWD_SP_LO, RFWD_SP_HI); // RQ9
    assign a_lgen = in_rng(i_addr, RFWD_LGEN_LO, RFWD_LGEN_HI); // RQ6
    assign a_ugen = in_rng(i_addr, RFWD_UGEN_LO, RFWD_UGEN_HI); // RQ6
    assign a_cram = in_rng(i_addr, RFWD_CRAM_LO, RFWD_CRAM_HI) && page_ok;
    assign a_irc = (i_addr == RFWD_IRC_ADDR) && !is_direct;
    assign a_psfr = in_rng(i_addr, RFWD_PSFR_LO, RFWD_PSFR_HI) && !is_direct;

    // Effective register-file index and target choice
    logic [9:0] reg_idx;
    logic [15:0] eff;
    rfwd_tgt_t tgt;
    logic reg_ok;
    assign eff = win_ureg ? win_tgt : i_addr;
    assign reg_idx = eff[9:0];
    // Direct upper access without a window is not decodable: go external
    assign reg_ok = win_ureg || (!hit_win && (a_sfr || a_sp || a_lgen))
                    || (!is_direct && a_ugen) || (is_direct && (a_sfr || a_sp || a_lgen));
    always_comb begin
        if (i_fetch && (a_sfr || a_sp || a_lgen || a_ugen)) begin
            tgt = RFWD_TGT_EXT; // RQ8
        end else if (win_msfr) begin
            tgt = RFWD_TGT_ONES; // RQ14
        end else if (win_psfr) begin
            tgt = RFWD_TGT_PERIPH;
        end else if (reg_ok && !hit_win) begin
            tgt = RFWD_TGT_REG;
        end else if (win_ureg) begin
            tgt = RFWD_TGT_REG;
        end else if (a_cram && (i_fetch || !is_direct) && !ext_sel_q) begin
            tgt = RFWD_TGT_CRAM; // RQ2 RQ4
        end else if (a_irc) begin
            tgt = RFWD_TGT_IRC;
        end else if (a_psfr) begin
            tgt = RFWD_TGT_PERIPH;
        end else begin
            tgt = RFWD_TGT_EXT;
        end
    end

    // ==========================================================
    // Storage strobes
    logic go, reg_we, cram_we, sel_wsel, sel_splo, sel_sphi;
    logic [7:0] reg_rd, cram_rd;
    assign go = i_ce && i_req;
    assign sel_wsel = (tgt == RFWD_TGT_REG) && !win_ureg && (i_addr == RFWD_WSEL_ADDR);
    assign sel_splo = (tgt == RFWD_TGT_REG) && !win_ureg && (i_addr == RFWD_SP_LO);
    assign sel_sphi = (tgt == RFWD_TGT_REG) && !win_ureg && (i_addr == RFWD_SP_HI);
    assign reg_we = i_we && (tgt == RFWD_TGT_REG) && !a_sp && !a_sfr;
    assign cram_we = i_we && go && (tgt == RFWD_TGT_CRAM);

    rfwd_ram #(
        .DEPTH(RFWD_REG_BYTES),
        .AW(10)
    ) u_reg_ram (
        .i_clk(i_clk),
        .i_ce(go),
        .i_we(reg_we || (i_we && win_ureg)),
        .i_addr(reg_idx),
        .i_wdata(i_wdata),
        .o_rdata(reg_rd)
    );
    rfwd_ram #(
        .DEPTH(RFWD_CRAM_BYTES),
        .AW(9)
    ) u_code_ram (
        .i_clk(i_clk),
        .i_ce(i_ce),
        .i_we(cram_we),
        .i_addr(i_addr[8:0]),
        .i_wdata(i_wdata),
        .o_rdata(cram_rd)
    );

    // ==========================================================
    // Stack pointer step; push pre-decrements, pop post-increments
    logic [15:0] sp_step, sp_d;
    assign sp_step = {13'h0000, i_mode_1m ? RFWD_SP_STEP_1M : RFWD_SP_STEP_64K};
    always_comb begin
        sp_d = sp_q;
        if (i_stk == RFWD_STK_PUSH) begin
            sp_d = sp_q - sp_step; // RQ10
        end else if (i_stk == RFWD_STK_POP) begin
            sp_d = sp_q + sp_step; // RQ11
        end else if (go && i_we && sel_splo) begin
            sp_d = {sp_q[15:8], i_wdata}; // RQ9
        end else if (go && i_we && sel_sphi) begin
            sp_d = {i_wdata, sp_q[7:0]};
        end
    end

    // Direct read of special registers the block owns
    logic [7:0] own_rd;
    assign own_rd = sel_wsel ? {hold_en_q, wsel_q} :
                    sel_splo ? sp_q[7:0] :
                    sel_sphi ? sp_q[15:8] :
                    (i_addr == 16'h0002 || i_addr == 16'h0003) ? RFWD_ALL_ONES : 8'h00; // RQ13

    // ==========================================================
    // Pin synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
        end else if (i_ce) begin
            pin_meta_q <= i_external_access_pin_b;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Control registers; stack ops only act with i_ce high
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wsel_q <= RFWD_WSEL_RESET;
            hold_en_q <= 1'b0;
            ext_sel_q <= RFWD_IRC_RESET[RFWD_IRC_EXT_BIT];
            sp_q <= RFWD_SP_RESET;
        end else if (i_ce) begin
            sp_q <= sp_d;
            if (go && i_we && sel_wsel) begin
                wsel_q <= i_wdata[6:0];
                hold_en_q <= i_wdata[RFWD_WSEL_HOLD_BIT]; // RQ16
            end
            if (go && i_we && (tgt == RFWD_TGT_IRC)) begin
                ext_sel_q <= i_wdata[RFWD_IRC_EXT_BIT]; // RQ4
            end
        end
    end

    // Request capture and outbound strobes
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rvalid_q <= 1'b0;
            tgt_q <= RFWD_TGT_REG;
            direct_q <= 8'h00;
            ext_req_q <= 1'b0;
            ext_addr_q <= 24'h000000;
            preq_q <= 1'b0;
            pwe_q <= 1'b0;
            paddr_q <= 16'h0000;
            pwdata_q <= 8'h00;
        end else if (i_ce) begin
            rvalid_q <= go && !i_we;
            tgt_q <= tgt;
            direct_q <= own_rd;
            ext_req_q <= go && (tgt == RFWD_TGT_EXT);
            ext_addr_q <= {i_page, i_addr};
            preq_q <= go && (tgt == RFWD_TGT_PERIPH);
            pwe_q <= go && i_we && (tgt == RFWD_TGT_PERIPH); // RQ14
            paddr_q <= win_psfr ? win_tgt : i_addr;
            pwdata_q <= i_wdata;
        end
    end

    // Read data select, one cycle after the request
    logic use_own;
    logic [7:0] irc_rd;
    assign irc_rd = {!pin_sync_q, ext_sel_q, 6'h00}; // RQ5
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            use_own <= 1'b0;
        end else if (i_ce) begin
            use_own <= sel_wsel || sel_splo || sel_sphi || a_sfr;
        end
    end
    logic [7:0] irc_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            irc_q <= RFWD_IRC_RESET;
        end else if (i_ce) begin
            irc_q <= irc_rd;
        end
    end
    logic [7:0] rd_mux;
    assign rd_mux = (tgt_q == RFWD_TGT_ONES) ? RFWD_ALL_ONES :
                    (tgt_q == RFWD_TGT_CRAM) ? cram_rd :
                    (tgt_q == RFWD_TGT_IRC) ? irc_q :
                    (tgt_q == RFWD_TGT_PERIPH) ? i_periph_rdata :
                    (tgt_q == RFWD_TGT_REG) ? (use_own ? direct_q : reg_rd) : 8'h00;

    // Outputs
    assign o_rdata = rd_mux;
    assign o_rvalid = rvalid_q;
    assign o_ext_req = ext_req_q;
    assign o_ext_addr = ext_addr_q;
    assign o_periph_req = preq_q;
    assign o_periph_we = pwe_q;
    assign o_periph_addr = paddr_q;
    assign o_periph_wdata = pwdata_q;
    assign o_stack_pointer = sp_q;
    assign o_bus_hold_enable = hold_en_q;
endmodule
`default_nettype wire

// ===== rfwd_top_assertions.sv
// Port checker for the register file window decoder.
// Assumes the clock enable is held high and one byte access per request.
`timescale 1ns/100ps
`default_nettype none
module rfwd_top_checker
    import rfwd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_external_access_pin_b,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic i_fetch,
    input wire rfwd_mode_t i_mode,
    input wire logic [7:0] i_page,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire rfwd_stk_t i_stk,
    input wire logic i_mode_1m,
    input wire logic [7:0] i_periph_rdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_ext_req,
    input wire logic [23:0] o_ext_addr,
    input wire logic o_periph_req,
    input wire logic o_periph_we,
    input wire logic [15:0] o_periph_addr,
    input wire logic [7:0] o_periph_wdata,
    input wire logic [15:0] o_stack_pointer,
    input wire logic o_bus_hold_enable
);
    // ==========================================================
    // Shared timing and step size
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic [2:0] step_w;
    assign step_w = i_mode_1m ? 3'h4 : 3'h2;
    sequence push_s;
        i_ce && !i_req && i_stk == RFWD_STK_PUSH;
    endsequence
    sequence pop_s;
        i_ce && !i_req && i_stk == RFWD_STK_POP;
    endsequence
    sequence fetch_s;
        i_ce && i_req && i_fetch && i_page == RFWD_PAGE_LO && i_addr <= RFWD_UGEN_HI;
    endsequence
    // ==========================================================
    // Properties
    rd_answer_a: assert property (o_rvalid |-> $past(i_req && i_ce && !i_we))
        else $error("read answer without read request");
    fetch_ext_a: assert property (fetch_s |=> o_ext_req && o_ext_addr == $past({i_page, i_addr}))
        else $error("register file fetch not sent external");
    ext_addr_a: assert property (o_ext_req |-> o_ext_addr == $past({i_page, i_addr}))
        else $error("external address wrong");
    win_periph_a: assert property (o_periph_req && $past(i_mode == RFWD_AM_DIRECT) |->
        o_periph_addr >= RFWD_PSFR_LO && o_periph_addr <= RFWD_PSFR_HI)
        else $error("window reached outside peripheral space");
    sp_push_a: assert property (push_s |=> o_stack_pointer == $past(o_stack_pointer) - $past(step_w))
        else $error("push step wrong");
    sp_pop_a: assert property (pop_s |=> o_stack_pointer == $past(o_stack_pointer) + $past(step_w))
        else $error("pop step wrong");
    sp_hold_a: assert property (i_ce && !i_req && i_stk == RFWD_STK_NONE |=> $stable(o_stack_pointer))
        else $error("stack pointer moved by itself");
    hold_bit_a: assert property ($changed(o_bus_hold_enable) |->
        $past(i_req && i_we && i_addr == RFWD_WSEL_ADDR))
        else $error("bus hold enable changed without selector write");
    ones_read_a: assert property (i_ce && i_req && !i_we && !i_fetch && i_page == 8'h00 &&
        i_addr == 16'h0002 |=> o_rvalid && o_rdata == 8'hFF)
        else $error("all-ones register wrong");
endmodule
bind rfwd_top rfwd_top_checker u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_external_access_pin_b(i_external_access_pin_b), .i_req(i_req), .i_we(i_we),
    .i_fetch(i_fetch), .i_mode(i_mode), .i_page(i_page), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_stk(i_stk), .i_mode_1m(i_mode_1m), .i_periph_rdata(i_periph_rdata), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_ext_req(o_ext_req), .o_ext_addr(o_ext_addr),
    .o_periph_req(o_periph_req), .o_periph_we(o_periph_we), .o_periph_addr(o_periph_addr),
    .o_periph_wdata(o_periph_wdata), .o_stack_pointer(o_stack_pointer),
    .o_bus_hold_enable(o_bus_hold_enable));
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for rfwd_top: window, stack, code RAM, control.
// Assumes the package, checker and peripheral model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench import rfwd_pkg::*;;
    localparam rfwd_mode_t DIR = RFWD_AM_DIRECT;
    localparam rfwd_mode_t IND = RFWD_AM_INDIRECT;
    logic i_clk = 1'b0, i_rst_b = 1'b0, pin_b = 1'b0, req = 1'b0, we = 1'b0;
    logic fetch = 1'b0, m1 = 1'b0, rvalid, ext_req, p_req, p_we, hold_en;
    rfwd_mode_t mode = DIR;
    rfwd_stk_t stk = RFWD_STK_NONE;
    logic [7:0] page = 8'h00, wdata = 8'h00, p_rdata, rdata, p_wdata, v1, v2;
    logic [15:0] addr = 16'h0000, p_addr, sp;
    logic [23:0] ext_addr;
    logic [31:0] lfsr_q = 32'h000111F4;
    logic [7:0] exp_q [$];
    int num_errors = 0, comparisons = 0, cycles = 0;
    // ==========================================================
    // Clock, design and far side
    always #25 i_clk = ~i_clk;
    rfwd_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
        .i_external_access_pin_b(pin_b), .i_req(req), .i_we(we), .i_fetch(fetch),
        .i_mode(mode), .i_page(page), .i_addr(addr), .i_wdata(wdata), .i_stk(stk),
        .i_mode_1m(m1), .i_periph_rdata(p_rdata), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_ext_req(ext_req), .o_ext_addr(ext_addr), .o_periph_req(p_req),
        .o_periph_we(p_we), .o_periph_addr(p_addr), .o_periph_wdata(p_wdata),
        .o_stack_pointer(sp), .o_bus_hold_enable(hold_en));
    rfwd_periph_model u_periph (.i_clk(i_clk), .i_req(p_req), .i_we(p_we),
        .i_addr(p_addr), .i_wdata(p_wdata), .o_rdata(p_rdata));
    // ==========================================================
    // Helpers
    task automatic rnd(output logic [7:0] v);
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        v = lfsr_q[7:0];
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic f, input rfwd_mode_t m, input logic [7:0] p,
                       input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #5;
        req = 1'b1;
        we = w;
        fetch = f;
        mode = m;
        page = p;
        addr = a;
        wdata = d;
        @(posedge i_clk);
        #5;
        req = 1'b0;
    endtask
    task automatic rd(input rfwd_mode_t m, input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, 1'b0, m, 8'h00, a, 8'h00);
    endtask
    task automatic stack_op(input rfwd_stk_t k, input logic m);
        @(posedge i_clk);
        #5;
        stk = k;
        m1 = m;
        @(posedge i_clk);
        #5;
        stk = RFWD_STK_NONE;
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Result watcher: each register answer meets the oldest note
    always @(negedge i_clk) begin
        if (rvalid === 1'b1 && ext_req !== 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("Error at %0t: unexpected read answer", $time);
            end else begin
                check(32'(rdata), 32'(exp_q.pop_front()));
            end
        end
    end
    // Hang guard, far above the roughly 80 cycles the run needs
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            end_sim();
        end
    end
    // ==========================================================
    // Scenarios
    initial begin
        logic [7:0] sel [3];
        logic [15:0] dadr [3];
        sel = '{8'h4A, 8'h25, 8'h12};
        dadr = '{16'h00EB, 16'h00CB, 16'h00CB};
        rnd(v1);
        rnd(v2);
        repeat (3) @(posedge i_clk);
        #5 i_rst_b = 1'b1;
        check(32'({hold_en, sp}), 32'h0);
        // Pin needs two edges through its synchroniser before it reads back
        repeat (2) @(posedge i_clk);
        rd(IND, 16'h1FE0, 8'h80);
        pin_b = 1'b1;
        acc(1'b1, 1'b0, IND, 8'h00, 16'h1FE0, 8'h40);
        rd(RFWD_AM_INDEXED, 16'h1FE0, 8'h40);
        acc(1'b1, 1'b0, IND, 8'h00, 16'h0400, v1);
        check(32'({ext_req, ext_addr}), 32'h01000400);
        acc(1'b1, 1'b0, IND, 8'h00, 16'h1FE0, 8'h00);
        acc(1'b1, 1'b0, IND, 8'h00, 16'h0400, v1);
        check(32'(ext_req), 32'h0);
        exp_q.push_back(v1);
        acc(1'b0, 1'b0, IND, 8'hFF, 16'h0400, 8'h00);
        acc(1'b0, 1'b1, IND, 8'h00, 16'h0100, 8'h00);
        check(32'({ext_req, ext_addr}), 32'h01000100);
        acc(1'b1, 1'b0, IND, 8'h00, 16'h014B, v2);
        acc(1'b1, 1'b0, DIR, 8'h00, 16'h00EB, v1);
        rd(DIR, 16'h00EB, v1);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 1'b0, DIR, 8'h00, RFWD_WSEL_ADDR, sel[i]);
            rd(DIR, dadr[i], v2);
        end
        acc(1'b1, 1'b0, DIR, 8'h00, RFWD_WSEL_ADDR, 8'hCA);
        check(32'(hold_en), 32'h1);
        rd(DIR, 16'h00EB, v2);
        acc(1'b1, 1'b0, DIR, 8'h00, RFWD_WSEL_ADDR, 8'h3E);
        acc(1'b1, 1'b0, DIR, 8'h00, 16'h00CC, v1);
        check({6'h00, p_req, p_we, p_addr, p_wdata}, {8'h03, 16'h1F8C, v1});
        rd(DIR, 16'h00CC, v1);
        acc(1'b1, 1'b0, DIR, 8'h00, RFWD_WSEL_ADDR, 8'h7F);
        rd(DIR, 16'h00E7, 8'hFF);
        acc(1'b1, 1'b0, DIR, 8'h00, 16'h00E0, 8'h40);
        acc(1'b1, 1'b0, DIR, 8'h00, RFWD_WSEL_ADDR, 8'h00);
        rd(IND, 16'h1FE0, 8'h00);
        rd(DIR, 16'h0002, 8'hFF);
        rd(DIR, 16'h0000, 8'h00);
        acc(1'b1, 1'b0, DIR, 8'h00, 16'h0018, 8'h00);
        acc(1'b1, 1'b0, DIR, 8'h00, 16'h0019, 8'h04);
        check(32'(sp), 32'h0400);
        rd(DIR, 16'h0019, 8'h04);
        for (int m = 0; m < 2; m++) begin
            stack_op(RFWD_STK_PUSH, m[0]);
            check(32'(sp), m ? 32'h03FC : 32'h03FE);
            stack_op(RFWD_STK_POP, m[0]);
            check(32'(sp), 32'h0400);
        end
        repeat (3) @(posedge i_clk);
        check(32'(exp_q.size()), 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
